// ---- design/mds_pkg.sv ----
// Constants shared by the masked event drum sequencer.
// Assumes a 100 MHz clock and a 16-bit register port addressed by word index.
package mds_pkg;
	// ----------------------------------------
	// Sizes and timing
	// ----------------------------------------
	localparam int STEPS = 16;
	localparam int DW = 16;
	localparam int AW = 8;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_UNIT_NS = 10_000_000;
	localparam int TICK_UNIT_CYC = TICK_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [4:0] FIRST_STEP = 5'h01;
	localparam logic [4:0] LAST_STEP = 5'h10;
	localparam logic [15:0] CPS_MAX = 16'h270f;
	localparam logic [15:0] BASE_MAX = 16'h270f;
	// ----------------------------------------
	// Register indexes
	// ----------------------------------------
	localparam logic [7:0] A_PATTERN = 8'h00;
	localparam logic [7:0] A_MASK = 8'h10;
	localparam logic [7:0] A_CPS = 8'h20;
	localparam logic [7:0] A_TICK_BASE = 8'h30;
	localparam logic [7:0] A_EVT_ASSIGN = 8'h31;
	localparam logic [7:0] A_STEP_COUNT = 8'h32;
	localparam logic [7:0] A_TIMER_VALUE = 8'h33;
	localparam logic [7:0] A_PRESET = 8'h34;
	localparam logic [7:0] A_CUR_STEP = 8'h35;
	localparam logic [7:0] A_WORD_OUT = 8'h36;
	localparam logic [7:0] A_FLAGS = 8'h37;
	localparam logic [7:0] A_IRQ_STAT = 8'h38;
	localparam logic [7:0] A_IRQ_CLR = 8'h39;
	localparam logic [7:0] A_IRQ_EN = 8'h3a;
	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int IRQ_W = 2;
	localparam int IRQ_STEP = 0;
	localparam int IRQ_DONE = 1;
	localparam int FLAG_DONE = 0;
	localparam logic [15:0] PRESET_RST = 16'h0001;
	localparam logic [15:0] BASE_RST = 16'h0001;
	localparam logic [15:0] ZERO16 = 16'h0000;
endpackage

// ---- design/mds_sequencer.sv ----
// Masked event drum sequencer: sixteen steps, sixteen masked outputs, word output.
// Assumes synchronous control inputs and a one-cycle-latency register port.
//
// Chosen here: the placing of the registers and the plain strobed port.
module mds_sequencer #(
	parameter int TICK_CYC = mds_pkg::TICK_UNIT_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Controller levels and contacts
	input wire logic i_run,
	input wire logic i_start,
	input wire logic i_jog,
	input wire logic i_drum_reset,
	input wire logic [15:0] i_event,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [15:0] o_rdata,
	// Drum outputs
	output logic [15:0] o_out,
	output logic [15:0] o_word_out,
	output logic o_sequence_complete_flag,
	output logic o_irq
);
	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	// Per-step patterns, masks and counts, then the shared registers
	logic [15:0] pattern_r [mds_pkg::STEPS];
	logic [15:0] mask_r [mds_pkg::STEPS];
	logic [15:0] cps_r [mds_pkg::STEPS];
	logic [15:0] base_r;
	logic [15:0] evt_assign_r;
	logic [4:0] preset_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_en_r;
	// ----------------------------------------
	// Drum state
	// ----------------------------------------
	logic [4:0] cur_r;
	logic [15:0] count_r;
	logic [15:0] timer_r;
	logic [31:0] pre_r;
	logic done_r;
	logic jog_d_r;
	logic run_d_r;
	logic [15:0] out_r;
	logic [15:0] rdata_r;
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire [3:0] idx = cur_r[3:0] - 4'h1;
	wire [3:0] a_lo = i_addr[3:0];
	wire hit_pat = i_addr[7:4] == mds_pkg::A_PATTERN[7:4];
	wire hit_mask = i_addr[7:4] == mds_pkg::A_MASK[7:4];
	wire hit_cps = i_addr[7:4] == mds_pkg::A_CPS[7:4];
	wire wr_base = i_we && i_addr == mds_pkg::A_TICK_BASE;
	wire wr_evt = i_we && i_addr == mds_pkg::A_EVT_ASSIGN;
	wire wr_clr = i_we && i_addr == mds_pkg::A_IRQ_CLR;
	wire wr_en = i_we && i_addr == mds_pkg::A_IRQ_EN;
	wire wr_preset = i_we && i_addr == mds_pkg::A_PRESET && i_wdata >= 16'(mds_pkg::FIRST_STEP)
		&& i_wdata <= 16'(mds_pkg::LAST_STEP);
	wire run_entry = i_run && !run_d_r;
	wire load = i_drum_reset || run_entry;
	wire jog_edge = i_jog && !jog_d_r;
	// Base tick counter
	// A base of zero cannot count in zero time, so it ticks like a base of one.
	wire unit = pre_r == 32'(TICK_CYC - 1);
	wire [15:0] timer_inc = timer_r + 16'h1;
	wire tick = unit && timer_inc >= base_r;
	wire evt_ok = !evt_assign_r[idx] || i_event[idx];
	wire timing = i_run && i_start && !done_r && !i_drum_reset;
	wire live = timing && evt_ok;
	wire reached = live && count_r == cps_r[idx];
	wire advance = !load && !done_r && (reached || jog_edge);
	wire at_last = cur_r == mds_pkg::LAST_STEP;
	wire finish = advance && at_last;
	wire restart = !timing || advance || load;
	wire [15:0] masked = pattern_r[idx] & mask_r[idx];
	wire [1:0] irq_set = {finish, advance && !at_last};
	wire [1:0] irq_nxt = (irq_stat_r & ~(wr_clr ? i_wdata[1:0] : 2'h0)) | irq_set;
	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [15:0] rd_nxt;
	always_comb begin
		rd_nxt = mds_pkg::ZERO16;
		if (hit_pat) begin
			rd_nxt = pattern_r[a_lo];
		end else if (hit_mask) begin
			rd_nxt = mask_r[a_lo];
		end else if (hit_cps) begin
			rd_nxt = cps_r[a_lo];
		end else begin
			case (i_addr)
				mds_pkg::A_TICK_BASE: rd_nxt = base_r;
				mds_pkg::A_EVT_ASSIGN: rd_nxt = evt_assign_r;
				mds_pkg::A_STEP_COUNT: rd_nxt = count_r;
				mds_pkg::A_TIMER_VALUE: rd_nxt = timer_r;
				mds_pkg::A_PRESET: rd_nxt = {11'h000, preset_r};
				mds_pkg::A_CUR_STEP: rd_nxt = {11'h000, cur_r};
				mds_pkg::A_WORD_OUT: rd_nxt = out_r;
				mds_pkg::A_FLAGS: rd_nxt = {15'h0000, done_r};
				mds_pkg::A_IRQ_STAT: rd_nxt = {14'h0000, irq_stat_r};
				mds_pkg::A_IRQ_EN: rd_nxt = {14'h0000, irq_en_r};
				default: rd_nxt = mds_pkg::ZERO16;
			endcase
		end
	end
	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			for (int i = 0; i < mds_pkg::STEPS; i++) begin
				pattern_r[i] <= mds_pkg::ZERO16;
				mask_r[i] <= mds_pkg::ZERO16;
				cps_r[i] <= mds_pkg::ZERO16;
			end
		end else if (i_we) begin
			if (hit_pat) begin
				pattern_r[a_lo] <= i_wdata;
			end
			if (hit_mask) begin
				mask_r[a_lo] <= i_wdata;
			end
			if (hit_cps) begin
				cps_r[a_lo] <= (i_wdata > mds_pkg::CPS_MAX) ? mds_pkg::CPS_MAX : i_wdata;
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			base_r <= mds_pkg::BASE_RST;
			evt_assign_r <= mds_pkg::ZERO16;
			preset_r <= mds_pkg::FIRST_STEP;
			irq_en_r <= 2'h0;
			irq_stat_r <= 2'h0;
			rdata_r <= mds_pkg::ZERO16;
		end else begin
			if (wr_base) begin
				base_r <= (i_wdata > mds_pkg::BASE_MAX) ? mds_pkg::BASE_MAX : i_wdata;
			end
			if (wr_evt) begin
				evt_assign_r <= i_wdata;
			end
			if (wr_preset) begin
				preset_r <= i_wdata[4:0];
			end
			if (wr_en) begin
				irq_en_r <= i_wdata[1:0];
			end
			irq_stat_r <= irq_nxt;
			rdata_r <= i_re ? rd_nxt : mds_pkg::ZERO16;
		end
	end
	// ----------------------------------------
	// Tick prescaler
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pre_r <= 32'h0;
			timer_r <= mds_pkg::ZERO16;
		end else if (restart) begin
			pre_r <= 32'h0;
			timer_r <= mds_pkg::ZERO16;
		end else if (unit) begin
			pre_r <= 32'h0;
			timer_r <= tick ? mds_pkg::ZERO16 : timer_inc;
		end else begin
			pre_r <= pre_r + 32'h1;
		end
	end
	// ----------------------------------------
	// Step sequencing
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			cur_r <= mds_pkg::FIRST_STEP;
			count_r <= mds_pkg::ZERO16;
			done_r <= 1'b0;
			jog_d_r <= 1'b0;
			run_d_r <= 1'b0;
		end else begin
			jog_d_r <= i_jog;
			run_d_r <= i_run;
			if (load) begin
				cur_r <= preset_r;
				count_r <= mds_pkg::ZERO16;
			end else if (advance) begin
				cur_r <= at_last ? cur_r : cur_r + 5'h1;
				count_r <= mds_pkg::ZERO16;
			end else if (live && tick) begin
				count_r <= count_r + 16'h1;
			end
			if (i_drum_reset) begin
				done_r <= 1'b0;
			end else if (finish) begin
				done_r <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			out_r <= mds_pkg::ZERO16;
		end else begin
			out_r <= i_run ? masked : mds_pkg::ZERO16;
		end
	end
	assign o_out = out_r;
	assign o_word_out = out_r;
	assign o_rdata = rdata_r;
	assign o_sequence_complete_flag = done_r;
	assign o_irq = |(irq_stat_r & irq_en_r);
	// ----------------------------------------
	// Check helpers
	// ----------------------------------------
	// Cycles since the tick period began. A base write in mid-period spoils
	// that period, so the tick length check skips the tick that ends it.
	logic [39:0] gap_r;
	logic gap_ok_r;
	wire [39:0] units = (base_r == mds_pkg::ZERO16) ? 40'h1 : 40'(base_r);
	wire [39:0] period = units * 40'(TICK_CYC);
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			gap_r <= 40'h0;
			gap_ok_r <= 1'b0;
		end else if (restart || tick) begin
			gap_r <= 40'h0;
			gap_ok_r <= 1'b1;
		end else begin
			gap_r <= gap_r + 40'h1;
			gap_ok_r <= gap_ok_r && !wr_base;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	mask_applied_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_run |=> o_out == ($past(masked)))
	else $error("output not masked pattern");
	start_gate_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_start && !load && !jog_edge |=> $stable(cur_r))
	else $error("step moved without start");
	event_gate_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		!evt_ok && !load && !advance |=> $stable(count_r))
	else $error("count moved with event false");
	step_advance_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		reached && !load && !done_r && !at_last |=> cur_r == $past(cur_r) + 5'h1)
	else $error("step did not advance");
	halt_done_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		done_r && !load |=> $stable(cur_r))
	else $error("moved after completion");
	preset_load_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_drum_reset |=> cur_r == $past(preset_r) && count_r == 16'h0)
	else $error("preset not loaded");
	jog_step_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		jog_edge && !load && !done_r && !at_last |=> cur_r == $past(cur_r) + 5'h1)
	else $error("jog did not advance");
	done_flag_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		finish && !i_drum_reset |=> o_sequence_complete_flag ##1 1'b1)
	else $error("completion flag missing");
	irq_level_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		finish && irq_en_r[mds_pkg::IRQ_DONE] && !wr_en |=> o_irq)
	else $error("interrupt not raised");
	run_entry_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		run_entry |=> cur_r == $past(preset_r))
	else $error("preset not loaded on run entry");
	preset_range_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_we && i_addr == mds_pkg::A_PRESET && !wr_preset |=> $stable(preset_r))
	else $error("out of range preset taken");
	preset_write_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_preset |=> preset_r == $past(i_wdata[4:0]))
	else $error("preset write lost");
	step_range_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		cur_r >= mds_pkg::FIRST_STEP && cur_r <= mds_pkg::LAST_STEP)
	else $error("current step out of range");
	count_start_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_start && !load && !advance |=> $stable(count_r))
	else $error("count moved without start");
	timer_hold_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		!timing |=> timer_r == mds_pkg::ZERO16)
	else $error("timer ran without start");
	// The tick length is measured by a counter of its own.
	tick_period_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		tick && !restart && gap_ok_r |-> gap_r == period - 40'h1)
	else $error("tick period differs from base");
	count_clear_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		advance || load |=> count_r == mds_pkg::ZERO16)
	else $error("count not cleared on step entry");
	zero_count_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		live && count_r == mds_pkg::ZERO16 && cps_r[idx] == mds_pkg::ZERO16
		&& !load && !done_r && !at_last |=> cur_r == $past(cur_r) + 5'h1)
	else $error("zero count step did not advance");
	done_hold_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		done_r && !i_drum_reset |=> o_sequence_complete_flag)
	else $error("completion flag dropped");
	word_match_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_run |=> o_word_out == $past(masked))
	else $error("word output not masked pattern");
	out_idle_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_run |=> o_out == mds_pkg::ZERO16)
	else $error("outputs driven outside run");
	step_read_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_re && i_addr == mds_pkg::A_CUR_STEP |=> o_rdata == {11'h000, $past(cur_r)})
	else $error("current step read wrong");
	count_read_a:
	assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_re && i_addr == mds_pkg::A_STEP_COUNT |=> o_rdata == $past(count_r))
	else $error("step count read wrong");
endmodule

// ---- dv/mds_ladder_model.sv ----
// Ladder-side model: run mode, start, jog, drum reset and event contacts.
// Assumes the bench calls its tasks from one procedural thread.
module mds_ladder_model (
	// Clock
	input wire logic i_clk,
	// Controller levels and contacts
	output logic o_run,
	output logic o_start,
	output logic o_jog,
	output logic o_drum_reset,
	output logic [15:0] o_event
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_run = 1'b0;
		o_start = 1'b0;
		o_jog = 1'b0;
		o_drum_reset = 1'b0;
		o_event = 16'h0000;
	end
	task automatic set_levels(input logic run, input logic start, input logic [15:0] evt);
		@(posedge i_clk);
		o_run <= run;
		o_start <= start;
		o_event <= evt;
	endtask
	task automatic jog();
		@(posedge i_clk);
		o_jog <= 1'b1;
		@(posedge i_clk);
		o_jog <= 1'b0;
	endtask
	task automatic drum_reset();
		@(posedge i_clk);
		o_drum_reset <= 1'b1;
		@(posedge i_clk);
		o_drum_reset <= 1'b0;
	endtask
endmodule

// ---- dv/masked_event_drum_sequencer_tb_top.sv ----
// Self-checking bench for the drum sequencer over its register port.
// Assumes a shortened tick of four clock cycles per unit.
module masked_event_drum_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_run, i_start, i_jog, i_drum_reset, i_we = 1'b0, i_re = 1'b0;
	logic [15:0] i_event, i_wdata = 16'h0000, o_rdata, o_out, o_word_out;
	logic [7:0] i_addr = 8'h00;
	logic o_sequence_complete_flag, o_irq;
	int mismatches = 0;
	int check_count = 0;
	always #5 i_clk = ~i_clk;
	mds_ladder_model u_mds_ladder_model (.i_clk(i_clk), .o_run(i_run), .o_start(i_start),
		.o_jog(i_jog), .o_drum_reset(i_drum_reset), .o_event(i_event));
	mds_sequencer #(.TICK_CYC(4)) u_mds_sequencer (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_run(i_run), .i_start(i_start), .i_jog(i_jog), .i_drum_reset(i_drum_reset),
		.i_event(i_event), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re),
		.o_rdata(o_rdata), .o_out(o_out), .o_word_out(o_word_out),
		.o_sequence_complete_flag(o_sequence_complete_flag), .o_irq(o_irq));
	function automatic logic [15:0] pat(input int k);
		return 16'h1234 + 16'(k) * 16'h0101;
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_we <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
		@(posedge i_clk);
		i_re <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_re <= 1'b0;
		#1;
		chk(what, exp, o_rdata);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge i_clk);
		mismatches++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge i_clk);
		i_nrst <= 1'b1;
		rd(mds_pkg::A_PRESET, mds_pkg::PRESET_RST, "preset");
		rd(mds_pkg::A_TICK_BASE, mds_pkg::BASE_RST, "base");
		rd(8'hff, 16'h0000, "unmapped");
		wr(mds_pkg::A_CUR_STEP, 16'h0007);
		rd(mds_pkg::A_CUR_STEP, 16'h0001, "step");
		for (int k = 0; k < 16; k++) begin
			wr(mds_pkg::A_MASK + 8'(k), 16'h0000);
			wr(mds_pkg::A_PATTERN + 8'(k), pat(k));
		end
		wr(mds_pkg::A_IRQ_EN, 16'h0003);
		$display("test reset done");
		u_mds_ladder_model.set_levels(1'b1, 1'b0, 16'h0000);
		wait_cyc(3);
		chk("out", 16'h0000, o_out);
		wr(mds_pkg::A_MASK, 16'h0ff0);
		wait_cyc(2);
		chk("out", pat(0) & 16'h0ff0, o_out);
		chk("word", pat(0) & 16'h0ff0, o_word_out);
		rd(mds_pkg::A_WORD_OUT, pat(0) & 16'h0ff0, "word reg");
		wait_cyc(20);
		rd(mds_pkg::A_CUR_STEP, 16'h0001, "step");
		rd(mds_pkg::A_TIMER_VALUE, 16'h0000, "timer");
		u_mds_ladder_model.jog();
		rd(mds_pkg::A_CUR_STEP, 16'h0002, "step");
		rd(mds_pkg::A_STEP_COUNT, 16'h0000, "count");
		$display("test mask and jog done");
		wr(mds_pkg::A_PRESET, 16'h0011);
		rd(mds_pkg::A_PRESET, 16'h0001, "preset");
		wr(mds_pkg::A_PRESET, 16'h0005);
		rd(mds_pkg::A_PRESET, 16'h0005, "preset");
		u_mds_ladder_model.drum_reset();
		rd(mds_pkg::A_CUR_STEP, 16'h0005, "step");
		u_mds_ladder_model.jog();
		rd(mds_pkg::A_CUR_STEP, 16'h0006, "step");
		u_mds_ladder_model.set_levels(1'b0, 1'b0, 16'h0000);
		u_mds_ladder_model.set_levels(1'b1, 1'b0, 16'h0000);
		rd(mds_pkg::A_CUR_STEP, 16'h0005, "step");
		$display("test preset done");
		wr(mds_pkg::A_PRESET, 16'h0001);
		u_mds_ladder_model.drum_reset();
		for (int k = 0; k < 16; k++) begin
			wr(mds_pkg::A_CPS + 8'(k), 16'h0002);
		end
		wr(mds_pkg::A_TICK_BASE, 16'h0002);
		wr(mds_pkg::A_EVT_ASSIGN, 16'h0001);
		u_mds_ladder_model.set_levels(1'b1, 1'b1, 16'h0000);
		wait_cyc(30);
		rd(mds_pkg::A_CUR_STEP, 16'h0001, "step");
		rd(mds_pkg::A_STEP_COUNT, 16'h0000, "count");
		u_mds_ladder_model.set_levels(1'b1, 1'b1, 16'h0001);
		rd(mds_pkg::A_CUR_STEP, 16'h0001, "step");
		wait_cyc(18);
		rd(mds_pkg::A_CUR_STEP, 16'h0002, "step");
		u_mds_ladder_model.set_levels(1'b1, 1'b0, 16'hffff);
		$display("test timed step done");
		for (int k = 0; k < 16; k++) begin
			wr(mds_pkg::A_CPS + 8'(k), 16'h0000);
		end
		u_mds_ladder_model.drum_reset();
		u_mds_ladder_model.set_levels(1'b1, 1'b1, 16'hffff);
		wait_cyc(12);
		chk("done", 16'h0000, 16'(o_sequence_complete_flag));
		wait_cyc(8);
		chk("done", 16'h0001, 16'(o_sequence_complete_flag));
		rd(mds_pkg::A_CUR_STEP, 16'h0010, "step");
		rd(mds_pkg::A_FLAGS, 16'h0001, "flags");
		rd(mds_pkg::A_IRQ_STAT, 16'h0003, "irq status");
		chk("irq", 16'h0001, 16'(o_irq));
		wr(mds_pkg::A_IRQ_CLR, 16'h0003);
		wait_cyc(1);
		chk("irq", 16'h0000, 16'(o_irq));
		u_mds_ladder_model.set_levels(1'b1, 1'b0, 16'hffff);
		u_mds_ladder_model.drum_reset();
		wait_cyc(1);
		chk("done", 16'h0000, 16'(o_sequence_complete_flag));
		rd(mds_pkg::A_CUR_STEP, 16'h0001, "step");
		$display("test completion done");
		end_of_test();
	end
endmodule
